// >>> design/instr_executor.sv
// Fetch, decode and execute core for the twelve-bit instruction subset.
// What this block does
// - Each instruction is one 12-bit word holding an opcode and operand fields.
// - Byte instructions pick one of 32 file registers by the five-bit file field.
// - Destination bit 0 writes the accumulator, 1 writes back the file register.
// - Bit instructions pick a bit of the 8-bit file register by the bit field.
// - Literal and control instructions take an 8-bit or 9-bit constant.
// - Instructions take one cycle, two when a test is true or the counter changes.
// - Each instruction cycle is four oscillator periods.
// - Complement inverts the file, stores per destination, updates zero, one cycle.
// - Decrement-skip stores the result, keeps flags, and flushes fetch on zero.
// - Branch loads 9 literal bits and takes page bits from status 6:5, two cycles.
`include "exec_regs.svh"
module instr_executor #(
  parameter int PC_WIDTH = 12,
  parameter int FILE_COUNT = 32
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [11:0] instr_word,
  input wire logic [7:0] file_rd_data,
  output logic [PC_WIDTH-1:0] pc_out,
  output logic [4:0] file_rd_addr,
  output exec_pkg::file_wr_t file_wr,
  output logic [7:0] acc_out,
  output logic [7:0] status_out,
  output logic [7:0] option_out,
  output logic cycle_end,
  output logic [1:0] phase_out
);
  // ----------------------------------------
  // Quarter-cycle phase counter
  // ----------------------------------------
  logic [1:0] phase_reg;
  logic [PC_WIDTH-1:0] pc_reg;
  logic [11:0] ir_reg;
  logic flush_reg;
  logic hold_pc_reg;
  logic [7:0] acc_reg;
  logic [7:0] status_reg;
  logic [7:0] option_reg;
  exec_pkg::decoded_t dec;
  wire [1:0] last_phase = 2'(`OSC_PER_CYCLE - 1);
  wire cyc_en = (phase_reg == last_phase);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  // ----------------------------------------
  // Decode and execute
  // ----------------------------------------
  // don't-care bits ignored
  instr_decode u_decode (
    .word(ir_reg),
    .dec(dec)
  );
  wire is_flushed = flush_reg;
  wire [7:0] comp_val = ~file_rd_data;
  wire [7:0] dec_val = file_rd_data - 8'h01;
  wire kind_complement_file = !is_flushed && dec.kind == exec_pkg::OPK_COMPLEMENT_FILE;
  wire kind_decrement_file = !is_flushed && dec.kind == exec_pkg::OPK_DECREMENT_FILE;
  wire kind_dsz = !is_flushed && dec.kind == exec_pkg::OPK_DECSZ;
  wire kind_move_accumulator_to_file = !is_flushed && dec.kind == exec_pkg::OPK_MOVE_ACCUMULATOR_TO_FILE;
  wire kind_branch = !is_flushed && dec.kind == exec_pkg::OPK_BRANCH;
  wire kind_option = !is_flushed && dec.kind == exec_pkg::OPK_OPTION;
  wire byte_op = kind_complement_file || kind_decrement_file || kind_dsz;
  wire [7:0] result = kind_complement_file ? comp_val : dec_val;
  wire skip_next = kind_dsz && (dec_val == 8'h00);
  wire flush_next = skip_next || kind_branch;
  wire [PC_WIDTH-1:0] branch_pc =
    PC_WIDTH'({status_reg[`STATUS_PAGE_LSB+1:`STATUS_PAGE_LSB], dec.literal});
  wire [PC_WIDTH-1:0] pc_step = pc_reg + PC_WIDTH'(1);
  // refetch after branch
  // The word fetched under a branch already comes from the target, so the flush cycle
  // fetches the target once more instead of stepping past it.
  wire [PC_WIDTH-1:0] pc_next = kind_branch ? branch_pc : (hold_pc_reg ? pc_reg : pc_step);
  wire wr_file = (byte_op && dec.dest_file) || kind_move_accumulator_to_file;
  wire wr_acc = byte_op && !dec.dest_file;
  wire [7:0] wr_data = kind_move_accumulator_to_file ? acc_reg : result;
  wire upd_zero = kind_complement_file || kind_decrement_file;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pc_reg <= PC_WIDTH'(`RST_PC);
      ir_reg <= 12'h000;
      flush_reg <= 1'b1;
      hold_pc_reg <= 1'b0;
      acc_reg <= `RST_ACC;
      status_reg <= `RST_STATUS;
      option_reg <= `RST_OPTION;
      file_wr <= '0;
    end else if (cyc_en) begin
      ir_reg <= instr_word;
      pc_reg <= pc_next;
      flush_reg <= flush_next;
      hold_pc_reg <= kind_branch;
      if (wr_acc) begin
        acc_reg <= result;
      end
      if (upd_zero) begin
        status_reg[`STATUS_ZERO_BIT] <= (result == 8'h00);
      end
      if (kind_option) begin
        option_reg <= acc_reg;
      end
      file_wr.we <= wr_file;
      file_wr.addr <= dec.file_sel;
      file_wr.data <= wr_data;
    end else begin
      file_wr.we <= 1'b0;
    end
  end
  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pc_out <= PC_WIDTH'(`RST_PC);
      file_rd_addr <= 5'h00;
      cycle_end <= 1'b0;
      phase_out <= 2'h0;
    end else begin
      pc_out <= pc_next;
      file_rd_addr <= (phase_reg == 2'h0) ? dec.file_sel : file_rd_addr;
      cycle_end <= cyc_en;
      phase_out <= phase_reg;
    end
  end
  assign acc_out = acc_reg;
  assign status_out = status_reg;
  assign option_out = option_reg;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_cycle_done;
    cyc_en;
  endsequence
  AST_PHASE_FOUR: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en |=> !cyc_en [*3] ##1 cyc_en) else $error("instruction cycle not four periods");
  AST_BRANCH_PC: assert property (@(posedge core_clk) disable iff (reset)
    s_cycle_done and kind_branch |=> pc_reg == $past(branch_pc))
    else $error("branch target wrong");
  AST_BRANCH_FLUSH: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && kind_branch |=> flush_reg) else $error("branch did not take two cycles");
  AST_SKIP: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && kind_dsz && dec_val == 8'h00 |=> flush_reg && !kind_dsz)
    else $error("skip not taken");
  AST_SKIP_FLAGS: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && kind_dsz |=> $stable(status_reg)) else $error("skip changed flags");
  AST_ZERO: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && upd_zero |=> status_reg[`STATUS_ZERO_BIT] == ($past(result) == 8'h00))
    else $error("zero flag wrong");
  AST_DEST_ACC: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && byte_op && !dec.dest_file |=> acc_reg == $past(result) && !file_wr.we)
    else $error("accumulator destination wrong");
  AST_DEST_FILE: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && byte_op && dec.dest_file |=> file_wr.we && file_wr.data == $past(result))
    else $error("file destination wrong");
  AST_MOVE_ACCUMULATOR_TO_FILE: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && kind_move_accumulator_to_file |=> file_wr.we && file_wr.data == acc_reg && $stable(status_reg))
    else $error("move to file wrong");
  AST_OPTION: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && kind_option |=> option_reg == acc_reg) else $error("option load wrong");
  AST_DECREMENT_FILE: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && kind_decrement_file |=> !flush_reg) else $error("decrement took two cycles");
  sequence s_branch_taken;
    cyc_en && kind_branch;
  endsequence
  sequence s_skip_taken;
    cyc_en && skip_next;
  endsequence
  sequence s_next_boundary;
    !cyc_en [*3] ##1 cyc_en;
  endsequence
  AST_BRANCH_TWO: assert property (@(posedge core_clk) disable iff (reset)
    s_branch_taken |=> s_next_boundary ##0 (hold_pc_reg && is_flushed))
    else $error("branch flush cycle missing");
  AST_SKIP_TWO: assert property (@(posedge core_clk) disable iff (reset)
    s_skip_taken |=> s_next_boundary ##0 (is_flushed && !hold_pc_reg))
    else $error("skip flush cycle missing");
  AST_REFETCH: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && hold_pc_reg |=> pc_reg == $past(pc_reg) && !flush_reg)
    else $error("branch target not refetched");
  AST_PC_STEP: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && !kind_branch && !hold_pc_reg |=> pc_reg == $past(pc_reg) + PC_WIDTH'(1))
    else $error("program counter did not step");
  AST_CYCLE_END: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en |=> cycle_end && phase_out == last_phase)
    else $error("cycle end marker wrong");
  AST_MID_CYCLE: assert property (@(posedge core_clk) disable iff (reset)
    !cyc_en |=> $stable(acc_reg) && $stable(status_reg) && $stable(pc_reg))
    else $error("state changed inside a cycle");
  AST_WE_PULSE: assert property (@(posedge core_clk) disable iff (reset)
    file_wr.we |=> !file_wr.we)
    else $error("write strobe longer than one clock");
  AST_FILE_ADDR: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && wr_file |=> file_wr.addr == $past(dec.file_sel))
    else $error("write address wrong");
  AST_RD_ADDR: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en |=> ##1 file_rd_addr == dec.file_sel)
    else $error("read address wrong");
  AST_FLAGS_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && !upd_zero |=> $stable(status_reg))
    else $error("flags changed");
  AST_ACC_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && !wr_acc |=> $stable(acc_reg))
    else $error("accumulator changed");
  AST_OPTION_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && !kind_option |=> $stable(option_reg))
    else $error("option changed");
  AST_LIT_EIGHT: assert property (@(posedge core_clk) disable iff (reset)
    dec.kind != exec_pkg::OPK_BRANCH |-> dec.literal[8] == 1'b0)
    else $error("eight-bit literal wrong");
  AST_FLUSH_QUIET: assert property (@(posedge core_clk) disable iff (reset)
    cyc_en && is_flushed |=> !file_wr.we)
    else $error("discarded word wrote a file");
endmodule : instr_executor

// >>> design/exec_regs.svh
// Encodings, field positions, reset values and timing counts of the instruction executor.
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FLD_F_LSB 0
`define FLD_F_MSB 4
`define FLD_D_BIT 5
`define FLD_B_LSB 5
`define FLD_B_MSB 7
`define FLD_K8_MSB 7
`define FLD_K9_MSB 8
// ----------------------------------------
// Encodings
// ----------------------------------------
`define OP_COMPLEMENT_FILE 6'h09
`define OP_DECREMENT_FILE 6'h03
`define OP_DECREMENT_SKIP_ZERO 6'h0b
`define OP_MOVE_ACC_TO_FILE 7'h01
`define OP_UNCONDITIONAL_BRANCH 3'h5
`define OP_NO_OPERATION 12'h000
`define OP_OPTION_LOAD 12'h002
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RST_PC 12'hfff
`define RST_OPTION 8'hff
`define RST_ACC 8'h00
`define RST_STATUS 8'h00
`define STATUS_ZERO_BIT 2
`define STATUS_PAGE_LSB 5
`define OSC_PER_CYCLE 4
`endif

// >>> design/exec_pkg.sv
// Types shared by the instruction executor files.
package exec_pkg;
  typedef enum logic [2:0] {
    OPK_NOP = 3'h0,
    OPK_COMPLEMENT_FILE = 3'h1,
    OPK_DECREMENT_FILE = 3'h2,
    OPK_DECSZ = 3'h3,
    OPK_MOVE_ACCUMULATOR_TO_FILE = 3'h4,
    OPK_BRANCH = 3'h5,
    OPK_OPTION = 3'h6,
    OPK_OTHER = 3'h7
  } op_kind_t;
  typedef struct packed {
    op_kind_t kind;
    logic [4:0] file_sel;
    logic dest_file;
    logic [2:0] bit_sel;
    logic [8:0] literal;
  } decoded_t;
  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] data;
  } file_wr_t;
endpackage : exec_pkg

// >>> design/instr_decode.sv
// Combinational splitter of a twelve-bit word into its operation and operand fields.
`include "exec_regs.svh"
module instr_decode (
  input wire logic [11:0] word,
  output exec_pkg::decoded_t dec
);
  wire is_byte6_complement_file = (word[11:6] == `OP_COMPLEMENT_FILE);
  wire is_byte6_decrement_file = (word[11:6] == `OP_DECREMENT_FILE);
  wire is_byte6_dsz = (word[11:6] == `OP_DECREMENT_SKIP_ZERO);
  wire is_move_accumulator_to_file = (word[11:5] == `OP_MOVE_ACC_TO_FILE);
  wire is_branch = (word[11:9] == `OP_UNCONDITIONAL_BRANCH);
  wire is_nop = (word == `OP_NO_OPERATION);
  wire is_option = (word == `OP_OPTION_LOAD);
  exec_pkg::op_kind_t kind;
  assign kind = is_byte6_complement_file ? exec_pkg::OPK_COMPLEMENT_FILE :
                is_byte6_decrement_file ? exec_pkg::OPK_DECREMENT_FILE :
                is_byte6_dsz ? exec_pkg::OPK_DECSZ :
                is_move_accumulator_to_file ? exec_pkg::OPK_MOVE_ACCUMULATOR_TO_FILE :
                is_branch ? exec_pkg::OPK_BRANCH :
                is_nop ? exec_pkg::OPK_NOP :
                is_option ? exec_pkg::OPK_OPTION : exec_pkg::OPK_OTHER;
  assign dec = '{
    kind: kind,
    file_sel: word[`FLD_F_MSB:`FLD_F_LSB],
    dest_file: word[`FLD_D_BIT],
    bit_sel: word[`FLD_B_MSB:`FLD_B_LSB],
    literal: is_branch ? word[`FLD_K9_MSB:0] : {1'b0, word[`FLD_K8_MSB:0]}
  };
endmodule : instr_decode

// >>> sim/mem_model.sv
// Program memory and file register model that sits on the far side of the executor.
module mem_model (
  input wire logic core_clk,
  input wire logic [11:0] pc,
  input wire logic [4:0] rd_addr,
  input wire exec_pkg::file_wr_t wr,
  output logic [11:0] word,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] rom [0:511];
  logic [7:0] files [0:31];
  // zero don't-care bits
  // Only nine address bits reach the array, so the reset address wraps to the last word.
  assign word = rom[pc[8:0]];
  assign rd_data = files[rd_addr];
  always @(posedge core_clk) begin
    if (wr.we === 1'b1) begin
      files[wr.addr] <= wr.data;
    end
  end
endmodule : mem_model

// >>> sim/tb_top.sv
// Self-checking bench for the instruction executor.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] w; logic [7:0] fin; logic [7:0] acc; logic [7:0] fout; logic z;} row_t;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] instr_word;
  logic [7:0] file_rd_data;
  logic [11:0] pc_out;
  logic [4:0] file_rd_addr;
  exec_pkg::file_wr_t file_wr;
  logic [7:0] acc_out;
  logic [7:0] status_out;
  logic [7:0] option_out;
  logic cycle_end;
  logic [1:0] phase_out;
  int failures = 0;
  int n_checks = 0;
  row_t rows [7];
  instr_executor u_dut (.core_clk(core_clk), .reset(reset), .instr_word(instr_word),
    .file_rd_data(file_rd_data), .pc_out(pc_out), .file_rd_addr(file_rd_addr),
    .file_wr(file_wr), .acc_out(acc_out), .status_out(status_out),
    .option_out(option_out), .cycle_end(cycle_end), .phase_out(phase_out));
  mem_model u_mem (.core_clk(core_clk), .pc(pc_out), .rd_addr(file_rd_addr),
    .wr(file_wr), .word(instr_word), .rd_data(file_rd_data));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // Reset is held two edges before memory is touched, so a write in flight cannot land late.
  task automatic hold_reset;
    @(negedge core_clk);
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    for (int i = 0; i < 512; i++) begin
      u_mem.rom[i] = 12'h000;
    end
    for (int i = 0; i < 32; i++) begin
      u_mem.files[i] = 8'h00;
    end
  endtask : hold_reset
  task automatic release_run(input int cycles);
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    repeat (cycles * 4) @(negedge core_clk);
  endtask : release_run
  initial begin
    #100us;
    failures++;
    final_report();
  end
  initial begin
    int cnt;
    rows[0] = '{12'h243, 8'h13, 8'hec, 8'h13, 1'b0};
    rows[1] = '{12'h264, 8'hff, 8'h00, 8'h00, 1'b1};
    rows[2] = '{12'h0e5, 8'h01, 8'h00, 8'h00, 1'b1};
    rows[3] = '{12'h0df, 8'h00, 8'hff, 8'h00, 1'b0};
    rows[4] = '{12'h2c6, 8'h05, 8'h04, 8'h05, 1'b0};
    rows[5] = '{12'h029, 8'h33, 8'h00, 8'h00, 1'b0};
    rows[6] = '{12'hf00, 8'h5a, 8'h00, 8'h5a, 1'b0};
    hold_reset();
    check("pc_reset", pc_out, 12'hfff);
    check("option_reset", {4'h0, option_out}, 12'h0ff);
    foreach (rows[i]) begin
      hold_reset();
      u_mem.files[rows[i].w[4:0]] = rows[i].fin;
      u_mem.rom[0] = rows[i].w;
      release_run(5);
      check("acc", {4'h0, acc_out}, {4'h0, rows[i].acc});
      check("file", {4'h0, u_mem.files[rows[i].w[4:0]]}, {4'h0, rows[i].fout});
      check("zero", {11'h000, status_out[2]}, {11'h000, rows[i].z});
    end
    // A taken skip and a branch each discard the word behind them.
    hold_reset();
    u_mem.files[3] = 8'h0f;
    u_mem.files[4] = 8'hff;
    u_mem.files[8] = 8'h01;
    u_mem.rom[0] = 12'h243;
    u_mem.rom[1] = 12'h027;
    u_mem.rom[2] = 12'h264;
    u_mem.rom[3] = 12'h2e8;
    u_mem.rom[4] = 12'h247;
    u_mem.rom[5] = 12'ha10;
    u_mem.rom[6] = 12'h263;
    u_mem.rom[7] = 12'h000;
    u_mem.rom[16] = 12'h002;
    u_mem.rom[17] = 12'ha11;
    release_run(16);
    check("skip_acc", {4'h0, acc_out}, 12'h0f0);
    check("skip_zero", {11'h000, status_out[2]}, 12'h001);
    check("file8", {4'h0, u_mem.files[8]}, 12'h000);
    check("file7", {4'h0, u_mem.files[7]}, 12'h0f0);
    check("file3", {4'h0, u_mem.files[3]}, 12'h00f);
    check("option", {4'h0, option_out}, 12'h0f0);
    check("page", {9'h000, pc_out[11:9]}, 12'h000);
    check("rd_addr", {7'h00, file_rd_addr}, 12'h011);
    cnt = 0;
    while (cycle_end !== 1'b1 && cnt < 20) begin
      @(negedge core_clk);
      cnt++;
    end
    cnt = 0;
    do begin
      @(negedge core_clk);
      cnt++;
    end while (cycle_end !== 1'b1 && cnt < 20);
    check("cycle_len", cnt[11:0], 12'h004);
    check("phase_end", {10'h000, phase_out}, 12'h003);
    final_report();
  end
endmodule : tb_top
